/* File: idc_pkg.sv */
// Constants and types shared by the input diagnostic config bank
package idc_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCAN_STEP_NS  = 1000;
    localparam int SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SCAN_LAST = 8'(SCAN_STEP_CYC - 1);
    localparam logic [7:0] FRAME_BITS = 8'h10;

    localparam logic [6:0] ADDR_BREAK   = 7'h00;
    localparam logic [6:0] ADDR_INPUT   = 7'h02;
    localparam logic [6:0] ADDR_PRIMARY = 7'h04;
    localparam logic [6:0] ADDR_CFG     = 7'h18;
    localparam logic [6:0] ADDR_CHEN    = 7'h1a;
    localparam logic [6:0] ADDR_RFS     = 7'h1c;
    localparam logic [6:0] ADDR_RFM     = 7'h1e;
    localparam logic [6:0] ADDR_LED     = 7'h20;
    localparam logic [6:0] ADDR_PIN     = 7'h22;
    localparam logic [6:0] ADDR_ALM     = 7'h24;
    localparam logic [6:0] ADDR_DUMMY   = 7'h26;

    localparam logic [7:0] RST_CFG     = 8'h00;
    localparam logic [7:0] RST_CHEN    = 8'hff;
    localparam logic [7:0] RST_RFS     = 8'h02;
    localparam logic [7:0] RST_RFM     = 8'h00;
    localparam logic [7:0] RST_LED     = 8'h00;
    localparam logic [7:0] RST_PIN     = 8'h00;
    localparam logic [7:0] RST_ALM     = 8'hc0;
    localparam logic [7:0] RST_PRIMARY = 8'h46;
    localparam logic [7:0] CFG_WMASK   = 8'h19;
    localparam logic [7:0] RFM_WMASK   = 8'h3f;

    localparam int CFG_POLICY  = 4;
    localparam int CFG_FREEZE  = 3;
    localparam int CFG_SHORTEN = 0;
    localparam int RFS_CLKERR  = 5;
    localparam int PIN_STICKY  = 7;
    localparam int PIN_DIR     = 6;
    localparam int PRI_POWERUP = 6;
    localparam int PRI_SUMMARY = 5;
    localparam int PRI_SLOW    = 2;
    localparam int PRI_SMISS   = 1;

    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;

    typedef struct packed {
        logic       check_error;
        logic       temp_alarm2;
        logic       temp_alarm1;
        logic       supply_low;
        logic       supply_missing;
        logic       break_any;
        logic       thermal_shutdown;
        logic       input_ref_open;
        logic       input_ref_short;
        logic       break_ref_open;
        logic       break_ref_short;
        logic [1:0] mode;
    } idc_field_s;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } idc_cmd_s;

    typedef enum logic [1:0] {
        SCAN_ROW0 = 2'b00,
        SCAN_ROW1 = 2'b01,
        SCAN_ROW2 = 2'b11
    } idc_row_e;
endpackage

/* File: idc_spi_link.sv */
// Serial link shifter running on the host's serial clock
`timescale 1ns/1ps
module idc_spi_link (
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] resp_i,
    output logic             miso_o,
    output logic [15:0]      frame_o,
    output logic [7:0]       count_o
);
    logic in_frame;

    // Cleared by the deselect itself, since this clock stops between frames
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // Restarted on the first edge of each frame; read by the system side after deselect
    always_ff @(posedge sclk_i) begin
        frame_o <= {frame_o[14:0], mosi_i};
        count_o <= in_frame ? count_o + 8'h01 : 8'h01;
    end

    // Past sixteen bits the incoming stream is passed on for a daisy chain
    always_comb begin
        if (!in_frame) begin
            miso_o = resp_i[15];
        end else if (count_o < 8'h10) begin
            miso_o = resp_i[4'(8'h0f - count_o)];
        end else begin
            miso_o = frame_o[15];
        end
    end
endmodule // idc_spi_link

/* File: idc_regs.sv */
// Configuration and diagnostic register bank with serial access
//
// Contract
// - Policy 0 clears supply flags per frame in modes 0 and 2, or on primary read; 1: read only.
// - Freeze bit holds all input and break filters at mid-scale.
// - Config bit 0 enables input-reference short detection.
// - Disabled channel: input off, current zero, input-state bit zero.
// - Clock count not multiple of eight rejects command, sets error flag.
// - Thermal shutdown sets flag, turns off inputs and indicator drivers.
// - Input-reference open flag latches on open or thermal, clears on read.
// - Input-reference short latches; channels disabled while short present.
// - Break-reference open latches on open, thermal, no break detect; resets 0x02.
// - Break-reference short latches until read.
// - Secondary enables let their flags set the primary summary bit.
// - Eight bits drive three-by-three matrix, each row lit one third.
// - Row 2 column 2 shows field supply above missing threshold.
// - Sticky 0: alert from live sources; 1: held until primary read.
// - Direction bit selects matrix drive or general-purpose outputs.
// - Alert mask gates each primary flag; check and power-up enabled.
// - Writes to the dummy address change nothing; normal data shifts out.
// - Summary clears on read only when secondary cleared or disabled.
`timescale 1ns/1ps
module idc_regs (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              mosi_i,
    output logic                   miso_o,
    input  idc_pkg::idc_field_s    field_i,
    input  wire logic [7:0]        input_state_i,
    input  wire logic [7:0]        break_status_i,
    input  wire logic [7:0]        break_detect_en_i,
    output logic [7:0]             channel_active_o,
    output logic                   input_ref_short_detect_en_o,
    output logic                   filter_freeze_o,
    output logic [2:0]             matrix_row_o,
    output logic [2:0]             matrix_col_o,
    output logic                   alert_pin_n_o
);

    function automatic logic [7:0] hold_flags(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic [7:0] clr);
        // Set wins over a clear in the same cycle
        hold_flags = set | (cur & ~clr);
    endfunction

    function automatic logic is_addr(input idc_pkg::idc_cmd_s c,
                                     input logic [6:0] a);
        is_addr = (c.addr == a);
    endfunction

    logic [29:0]         sync1;
    logic [29:0]         sync2;
    logic                cs_d;
    idc_pkg::idc_field_s fs;
    logic [7:0]          di_s;
    logic [7:0]          wb_s;
    logic                cs_s;

    logic [15:0]         frame_w;
    logic [7:0]          bit_cnt;
    idc_pkg::idc_cmd_s   cmd;
    logic [15:0]         resp;

    logic [7:0]          cfg;
    logic [7:0]          chen;
    logic [7:0]          rfs;
    logic [7:0]          rfm;
    logic [7:0]          indicator_matrix;
    logic [7:0]          pin;
    logic [7:0]          alm;
    logic [7:0]          pri;

    logic                frame_end;
    logic                len_ok;
    logic                valid;
    logic                wr;
    logic                rd;
    logic                rd_pri;
    logic                rd_rfs;
    logic                therm;
    logic                short_now;
    logic [7:0]          sec_set;
    logic                frame_clr;
    logic                supply_clr;
    logic [7:0]          pri_hold;
    logic [7:0]          next_pri;
    logic [7:0]          rt_src;
    logic [7:0]          rd_data;
    logic [8:0]          pattern;

    logic [7:0]          step;
    idc_pkg::idc_row_e   row;
    idc_pkg::idc_row_e   next_row;
    logic [2:0]          row_hot;
    logic [2:0]          row_cols;

    // Deselect, field, input-state and break-status levels pass two flops before any use
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sync1 <= 30'h2000_0000;
            sync2 <= 30'h2000_0000;
            cs_d  <= 1'b1;
        end else begin
            sync1 <= {cs_n_i, field_i, input_state_i, break_status_i};
            sync2 <= sync1;
            cs_d  <= sync2[29];
        end
    end

    assign cs_s = sync2[29];
    assign fs   = sync2[28:16];
    assign di_s = sync2[15:8];
    assign wb_s = sync2[7:0];

    idc_spi_link u_link (
        .sclk_i  (sclk_i),
        .cs_n_i  (cs_n_i),
        .mosi_i  (mosi_i),
        .resp_i  (resp),
        .miso_o  (miso_o),
        .frame_o (frame_w),
        .count_o (bit_cnt)
    );

    // Link words are static here: the serial clock has stopped before the
    // synchronised deselect edge is seen
    assign cmd       = frame_w;
    assign frame_end = cs_s & ~cs_d;
    assign len_ok    = frame_end & (bit_cnt[2:0] == 3'h0) & (bit_cnt != 8'h00);
    assign valid     = frame_end & (bit_cnt == idc_pkg::FRAME_BITS);
    assign wr        = valid & cmd.write;
    assign rd        = valid & ~cmd.write;
    assign rd_pri    = rd & is_addr(cmd, idc_pkg::ADDR_PRIMARY);
    assign rd_rfs    = rd & is_addr(cmd, idc_pkg::ADDR_RFS);

    assign therm     = fs.thermal_shutdown;
    assign short_now = fs.input_ref_short & cfg[idc_pkg::CFG_SHORTEN];

    // Secondary fault sources as live levels
    always_comb begin
        sec_set    = 8'h00;
        sec_set[5] = frame_end & (bit_cnt[2:0] != 3'h0);
        sec_set[4] = therm;
        sec_set[3] = fs.input_ref_open | therm;
        sec_set[2] = short_now;
        sec_set[1] = fs.break_ref_open | therm | ~|break_detect_en_i;
        sec_set[0] = fs.break_ref_short;
    end

    // Secondary flags: latched, cleared by their own read
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rfs <= idc_pkg::RST_RFS;
        end else begin
            rfs <= hold_flags(rfs, sec_set, {8{rd_rfs}});
        end
    end

    // Frame clearing of supply flags only in modes 0 and 2
    assign frame_clr  = len_ok & ~cfg[idc_pkg::CFG_POLICY]
                      & (fs.mode == idc_pkg::MODE_0 | fs.mode == idc_pkg::MODE_2);
    assign supply_clr = rd_pri | frame_clr;
    assign pri_hold   = hold_flags(pri,
                                   {3'h0, fs.temp_alarm2, fs.temp_alarm1,
                                    fs.supply_low, fs.supply_missing, 1'b0},
                                   {3'h0, rd_pri, rd_pri, supply_clr, supply_clr, 1'b0});

    always_comb begin
        next_pri    = pri_hold;
        next_pri[7] = fs.check_error;
        next_pri[6] = pri[6] & ~(wr & is_addr(cmd, idc_pkg::ADDR_PRIMARY)
                                 & ~cmd.data[6]);
        // Read clears the summary only if no enabled secondary flag remains
        next_pri[5] = |(rfs & rfm) | (pri[5] & ~rd_pri);
        next_pri[0] = fs.break_any;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pri <= idc_pkg::RST_PRIMARY;
        end else begin
            pri <= next_pri;
        end
    end

    // Host-written registers; dummy and unknown addresses fall through
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg  <= idc_pkg::RST_CFG;
            chen <= idc_pkg::RST_CHEN;
            rfm  <= idc_pkg::RST_RFM;
            indicator_matrix  <= idc_pkg::RST_LED;
            pin  <= idc_pkg::RST_PIN;
            alm  <= idc_pkg::RST_ALM;
        end else if (wr) begin
            case (cmd.addr)
                idc_pkg::ADDR_CFG: begin
                    cfg <= cmd.data & idc_pkg::CFG_WMASK;
                end
                idc_pkg::ADDR_CHEN: begin
                    chen <= cmd.data;
                end
                idc_pkg::ADDR_RFM: begin
                    rfm <= cmd.data & idc_pkg::RFM_WMASK;
                end
                idc_pkg::ADDR_LED: begin
                    indicator_matrix <= cmd.data;
                end
                idc_pkg::ADDR_PIN: begin
                    pin <= cmd.data;
                end
                idc_pkg::ADDR_ALM: begin
                    alm <= cmd.data;
                end
                default: begin
                    cfg <= cfg;
                end
            endcase
        end
    end

    always_comb begin
        case (cmd.addr)
            idc_pkg::ADDR_BREAK:   rd_data = wb_s;
            idc_pkg::ADDR_INPUT:   rd_data = di_s & channel_active_o;
            idc_pkg::ADDR_PRIMARY: rd_data = pri;
            idc_pkg::ADDR_CFG:     rd_data = cfg;
            idc_pkg::ADDR_CHEN:    rd_data = chen;
            idc_pkg::ADDR_RFS:     rd_data = rfs;
            idc_pkg::ADDR_RFM:     rd_data = rfm;
            idc_pkg::ADDR_LED:     rd_data = indicator_matrix;
            idc_pkg::ADDR_PIN:     rd_data = pin;
            idc_pkg::ADDR_ALM:     rd_data = alm;
            default:               rd_data = 8'h00;
        endcase
    end

    // Reply for the next frame: input byte, then read data or break byte
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            resp <= 16'h0000;
        end else if (frame_end) begin
            resp <= {di_s & channel_active_o, rd ? rd_data : wb_s};
        end
    end

    // Channel gating; bit n is input pin n+1
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            channel_active_o <= 8'h00;
        end else begin
            channel_active_o <= chen & ~{8{short_now | therm}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            input_ref_short_detect_en_o <= 1'b0;
            filter_freeze_o             <= 1'b0;
        end else begin
            input_ref_short_detect_en_o <= cfg[idc_pkg::CFG_SHORTEN];
            filter_freeze_o             <= cfg[idc_pkg::CFG_FREEZE];
        end
    end

    // Matrix scan: equal dwell per row gives each a third
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            step <= 8'h00;
        end else if (step == idc_pkg::SCAN_LAST) begin
            step <= 8'h00;
        end else begin
            step <= step + 8'h01;
        end
    end

    always_comb begin
        case (row)
            idc_pkg::SCAN_ROW0: next_row = idc_pkg::SCAN_ROW1;
            idc_pkg::SCAN_ROW1: next_row = idc_pkg::SCAN_ROW2;
            default:            next_row = idc_pkg::SCAN_ROW0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            row <= idc_pkg::SCAN_ROW0;
        end else if (step == idc_pkg::SCAN_LAST) begin
            row <= next_row;
        end
    end

    // Corner INDICATOR_MATRIX shows the field supply is present
    assign pattern = {~fs.supply_missing, indicator_matrix};

    always_comb begin
        case (row)
            idc_pkg::SCAN_ROW0: begin
                row_hot  = 3'b001;
                row_cols = pattern[2:0];
            end
            idc_pkg::SCAN_ROW1: begin
                row_hot  = 3'b010;
                row_cols = pattern[5:3];
            end
            default: begin
                row_hot  = 3'b100;
                row_cols = pattern[8:6];
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            matrix_row_o <= 3'h0;
            matrix_col_o <= 3'h0;
        end else if (therm) begin
            matrix_row_o <= 3'h0;
            matrix_col_o <= 3'h0;
        end else if (pin[idc_pkg::PIN_DIR]) begin
            matrix_row_o <= pin[5:3];
            matrix_col_o <= pin[2:0];
        end else begin
            matrix_row_o <= row_hot;
            matrix_col_o <= row_cols;
        end
    end

    // Alert pin; summary source is the latched state, so a one-cycle error is not lost
    assign rt_src = {fs.check_error, pri[6], |(rfs & rfm), fs.temp_alarm2,
                     fs.temp_alarm1, fs.supply_low, fs.supply_missing, fs.break_any};

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            alert_pin_n_o <= 1'b1;
        end else if (pin[idc_pkg::PIN_STICKY]) begin
            alert_pin_n_o <= ~|(pri & alm);
        end else begin
            alert_pin_n_o <= ~|(rt_src & alm);
        end
    end

    property p_chan_off;
        @(posedge clk_i) disable iff (!rstn_i)
        !chen[1] |=> !channel_active_o[1] && (!resp[9] || !$past(frame_end));
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("disabled channel active");

    property p_clk_err;
        @(posedge clk_i) disable iff (!rstn_i)
        frame_end && bit_cnt[2:0] != 3'h0 |=> rfs[idc_pkg::RFS_CLKERR]
            && $stable(cfg) && $stable(chen);
    endproperty
    a_clk_err: assert property (p_clk_err) else $error("bad clock count not flagged");

    property p_short_off;
        @(posedge clk_i) disable iff (!rstn_i)
        short_now |=> channel_active_o == 8'h00 && rfs[2];
    endproperty
    a_short_off: assert property (p_short_off) else $error("short left channels on");

    property p_therm_off;
        @(posedge clk_i) disable iff (!rstn_i)
        therm ##1 therm |=> matrix_row_o == 3'h0 && matrix_col_o == 3'h0
            && rfs[4] && channel_active_o == 8'h00;
    endproperty
    a_therm_off: assert property (p_therm_off) else $error("thermal shutdown ignored");

    property p_summary_clr;
        @(posedge clk_i) disable iff (!rstn_i)
        rd_pri && (rfs & rfm) == 8'h00 |=> !pri[idc_pkg::PRI_SUMMARY];
    endproperty
    a_summary_clr: assert property (p_summary_clr) else $error("summary not cleared");

    property p_summary_set;
        @(posedge clk_i) disable iff (!rstn_i)
        (rfs & rfm) != 8'h00 |=> pri[idc_pkg::PRI_SUMMARY];
    endproperty
    a_summary_set: assert property (p_summary_set) else $error("summary not set");

    property p_policy_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg[idc_pkg::CFG_POLICY] && !rd_pri && pri[idc_pkg::PRI_SLOW]
            |=> pri[idc_pkg::PRI_SLOW];
    endproperty
    a_policy_hold: assert property (p_policy_hold) else $error("supply flag lost");

    property p_sticky;
        @(posedge clk_i) disable iff (!rstn_i)
        pin[idc_pkg::PIN_STICKY] && |(pri & alm) |=> !alert_pin_n_o;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky alert released");

    property p_scan;
        @(posedge clk_i) disable iff (!rstn_i)
        !pin[idc_pkg::PIN_DIR] && !therm ##1 !pin[idc_pkg::PIN_DIR] && !therm
            |-> $onehot(matrix_row_o);
    endproperty
    a_scan: assert property (p_scan) else $error("scan row not one-hot");

    property p_dummy;
        @(posedge clk_i) disable iff (!rstn_i)
        wr && is_addr(cmd, idc_pkg::ADDR_DUMMY) |=> $stable(cfg) && $stable(chen)
            && $stable(rfm) && $stable(indicator_matrix) && $stable(pin) && $stable(alm);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy write changed state");

endmodule // idc_regs

/* File: idc_host_model.sv */
// Host serial master model for the config bank link
`timescale 1ns/1ps
module idc_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Whole bytes unless a broken count is asked for
    // Dummy address writes shift out the reply left by the previous frame
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        // Off the system edge: link phase stays unrelated
        #1;
        r = 16'h0000;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_o = (i < 16) ? w[15-i] : 1'b0;
            #24;
            r = {r[14:0], miso_i};
            sclk_o = 1'b1;
            #24;
            sclk_o = 1'b0;
        end
        #24;
        cs_n_o = 1'b1;
        // Released line shows the inverse, never a stale bit
        mosi_o = ~mosi_o;
        #47;
    endtask
endmodule // idc_host_model

/* File: idc_regs_tb.sv */
// Self-checking bench for the config and diagnostic bank
`timescale 1ns/1ps
module idc_regs_tb;
    logic                clk_i;
    logic                rstn_i;
    logic                sclk;
    logic                cs_n;
    logic                mosi;
    logic                miso;
    idc_pkg::idc_field_s field_i;
    logic [7:0]          in_state;
    logic [7:0]          wb_in;
    logic [7:0]          wb_en;
    logic [7:0]          chan_act;
    logic                short_en;
    logic                freeze;
    logic [2:0]          row;
    logic [2:0]          col;
    logic                alert_n;
    logic [15:0]         r;
    logic [7:0]          d;
    int                  err_total;
    int                  checks;
    int                  cyc;

    idc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    idc_regs DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .field_i(field_i), .input_state_i(in_state),
        .break_status_i(wb_in), .break_detect_en_i(wb_en), .channel_active_o(chan_act),
        .input_ref_short_detect_en_o(short_en), .filter_freeze_o(freeze),
        .matrix_row_o(row), .matrix_col_o(col), .alert_pin_n_o(alert_n)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer({1'b1, a, v}, 16, r);
    endtask
    task automatic rc(input logic [6:0] a, input logic [7:0] exp);
        host.xfer({1'b0, a, 8'h00}, 16, r);
        host.xfer({1'b1, idc_pkg::ADDR_DUMMY, 8'h00}, 16, r);
        d = r[7:0];
        chk(d, exp);
    endtask
    // Bounded wait: a stuck scan must not hang the run
    task automatic scan(input logic [2:0] w, input logic [2:0] c);
        for (int i = 0; i < 1000 && row !== w; i++) @(posedge clk_i);
        chk(8'({row, col}), 8'({w, c}));
    endtask

    task automatic t_reset();
        chk(8'(alert_n), 8'h00);
        rc(idc_pkg::ADDR_CFG, 8'h00);
        rc(idc_pkg::ADDR_CHEN, 8'hff);
        rc(idc_pkg::ADDR_RFS, 8'h02);
        rc(idc_pkg::ADDR_RFS, 8'h00);
        rc(idc_pkg::ADDR_RFM, 8'h00);
        rc(idc_pkg::ADDR_LED, 8'h00);
        rc(idc_pkg::ADDR_PIN, 8'h00);
        rc(idc_pkg::ADDR_ALM, 8'hc0);
        $display("test reset done");
    endtask
    task automatic t_cfg();
        wr(idc_pkg::ADDR_CFG, 8'hff);
        chk(8'({freeze, short_en}), 8'h03);
        rc(idc_pkg::ADDR_CFG, 8'h19);
        wr(idc_pkg::ADDR_CFG, 8'h00);
        chk(8'({freeze, short_en}), 8'h00);
        wr(idc_pkg::ADDR_RFM, 8'hff);
        rc(idc_pkg::ADDR_RFM, 8'h3f);
        wr(idc_pkg::ADDR_RFM, 8'h00);
        rc(7'h30, 8'h00);
        $display("test config done");
    endtask
    task automatic t_chen();
        wr(idc_pkg::ADDR_CHEN, 8'h01);
        chk(chan_act, 8'h01);
        rc(idc_pkg::ADDR_CHEN, 8'h01);
        chk(r[15:8], 8'h01);
        wr(idc_pkg::ADDR_CHEN, 8'hff);
        $display("test channel enable done");
    endtask
    task automatic t_alert();
        wr(idc_pkg::ADDR_PRIMARY, 8'h00);
        chk(8'(alert_n), 8'h01);
        wr(idc_pkg::ADDR_RFM, 8'h20);
        wr(idc_pkg::ADDR_ALM, 8'h20);
        host.xfer(16'hffff, 12, r);
        chk(8'(alert_n), 8'h00);
        rc(idc_pkg::ADDR_CFG, 8'h00);
        rc(idc_pkg::ADDR_PRIMARY, 8'h20);
        chk(8'(alert_n), 8'h00);
        rc(idc_pkg::ADDR_RFS, 8'h20);
        rc(idc_pkg::ADDR_PRIMARY, 8'h20);
        chk(8'(alert_n), 8'h01);
        $display("test alert done");
    endtask
    task automatic t_fault();
        field_i.input_ref_short <= 1'b1;
        field_i.break_ref_short <= 1'b1;
        wb_en <= 8'h00;
        repeat (6) @(posedge clk_i);
        chk(chan_act, 8'hff);
        wr(idc_pkg::ADDR_CFG, 8'h01);
        chk(chan_act, 8'h00);
        field_i.input_ref_short <= 1'b0;
        field_i.break_ref_short <= 1'b0;
        wb_en <= 8'hff;
        repeat (6) @(posedge clk_i);
        chk(chan_act, 8'hff);
        rc(idc_pkg::ADDR_RFS, 8'h07);
        wr(idc_pkg::ADDR_CFG, 8'h10);
        wr(idc_pkg::ADDR_PIN, 8'h80);
        wr(idc_pkg::ADDR_ALM, 8'h04);
        field_i.supply_low <= 1'b1;
        repeat (4) @(posedge clk_i);
        field_i.supply_low <= 1'b0;
        wr(idc_pkg::ADDR_DUMMY, 8'h00);
        chk(8'(alert_n), 8'h00);
        rc(idc_pkg::ADDR_PRIMARY, 8'h04);
        chk(8'(alert_n), 8'h01);
        wr(idc_pkg::ADDR_CFG, 8'h00);
        field_i.mode <= idc_pkg::MODE_2;
        field_i.supply_low <= 1'b1;
        repeat (4) @(posedge clk_i);
        field_i.supply_low <= 1'b0;
        wr(idc_pkg::ADDR_DUMMY, 8'h00);
        rc(idc_pkg::ADDR_PRIMARY, 8'h00);
        $display("test fault done");
    endtask
    task automatic t_matrix();
        wr(idc_pkg::ADDR_LED, 8'h07);
        wr(idc_pkg::ADDR_DUMMY, 8'hff);
        chk(r[7:0], 8'h5a);
        rc(idc_pkg::ADDR_LED, 8'h07);
        scan(3'b001, 3'b111);
        scan(3'b100, 3'b100);
        wr(idc_pkg::ADDR_PIN, 8'h6b);
        chk(8'({row, col}), 8'h2b);
        wr(idc_pkg::ADDR_PIN, 8'h00);
        $display("test matrix done");
    endtask
    task automatic t_therm();
        field_i.thermal_shutdown <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(chan_act, 8'h00);
        chk(8'({row, col}), 8'h00);
        rc(idc_pkg::ADDR_RFS, 8'h1a);
        $display("test thermal done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Run needs about 14000 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        rstn_i = 1'b0;
        field_i = '0;
        in_state = 8'hff;
        wb_in = 8'h5a;
        wb_en = 8'hff;
        err_total = 0;
        checks = 0;
        cyc = 0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_reset();
        t_cfg();
        t_chen();
        t_alert();
        t_fault();
        t_matrix();
        @(posedge clk_i);
        t_therm();
        print_verdict();
    end
endmodule // idc_regs_tb
